/* File: src/flash_mode_current_map.svh */
// Operation
// [R01] Operating mode select 00 is shutdown, 01 DC-light, 10 flashlight and 11 constant voltage source.
// [R02] The host refreshes the mode select within 13 s, otherwise the device shuts down on the refresh timeout.
// [R03] A write to bits 7:6 of the mode/centre-current register also updates bits 7:6 of the mode/outer-current register.
// [R04] A write to bits 6:5 of the mode/outer-current register also updates bits 6:5 of the mode/centre-current register.
// [R05] With voltage_mode_force set the device runs as a constant voltage source, with it clear it runs normally.
// [R06] A read always returns zero in the voltage_mode_force bit position.
// [R07] With both flash levels zero the LEDs stay off and the converter regulates to output_voltage_setting.
// [R08] With high_current_select low the outer level steps by 27.75 mA per code.
// [R09] With high_current_select high the outer level uses the larger scale, 64.5 mA for code 1.
// [R10] The centre level follows high_current_select, code 0 disables it and code 1 gives 28.0 mA in the low scale.
// [R11] In the high-current scale centre codes of 100000 and above saturate at 2052 mA.
// [R12] Mode select 00 shuts the device down only when voltage_mode_force is clear.
// [R13] high_current_select low is direct drive from the battery, high draws from the reservoir capacitor.
// [R14] The host updates a register with one write of address byte then data byte, committed on the acknowledge.
// [R15] Every write that updates the mode select restarts the refresh timeout, whose expiry forces shutdown.
`ifndef FLASH_MODE_CURRENT_MAP_SVH
`define FLASH_MODE_CURRENT_MAP_SVH
`define CENTER_REG_ADDR   8'h01
`define OUTER_REG_ADDR    8'h02
`define CENTER_REG_RESET  8'h10
`define OUTER_REG_RESET   8'h08
`define MODE_MSB          7
`define MODE_LSB          6
`define FORCE_BIT         5
`define MIRROR_MSB        6
`define MIRROR_LSB        5
`define CENTER_LEVEL_MSB  5
`define OUTER_LEVEL_MSB   4
`define CLK_HZ            125000000
`define REFRESH_S         13
`define REFRESH_CYCLES    (`REFRESH_S * `CLK_HZ)
`endif

/* File: src/flash_mode_pkg.sv */
package flash_mode_pkg;
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'h0,
    MODE_DCLIGHT  = 2'h1,
    MODE_FLASH    = 2'h2,
    MODE_VOLTAGE  = 2'h3
  } opmode_t;

  typedef enum {
    OP_OFF,
    OP_DCLIGHT,
    OP_FLASH,
    OP_VOLTAGE
  } opstate_t;

  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } regwr_t;

  typedef struct packed {
    logic        ledsOn;
    logic        voltageReg;
    logic        directDrive;
    logic [11:0] centerMilliAmp;
    logic [11:0] outerMilliAmp;
  } drive_t;
endpackage : flash_mode_pkg

/* File: src/refresh_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "flash_mode_current_map.svh"
module refresh_timer #(
  parameter int unsigned LIMIT = `REFRESH_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic restart,
  output var  logic expired
);
  logic [31:0] count_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_r <= 32'h0;
      expired <= 1'b0;
    end
    else if (restart)
    begin
      count_r <= 32'h0;
      expired <= 1'b0;
    end
    else if (count_r >= LIMIT - 1)
    begin
      expired <= 1'b1;
    end
    else
    begin
      count_r <= count_r + 32'h1;
      expired <= 1'b0;
    end
  end
endmodule : refresh_timer
`default_nettype wire

/* File: src/flash_mode_current_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "flash_mode_current_map.svh"
module flash_mode_current_regs #(
  parameter int unsigned REFRESH_LIMIT = `REFRESH_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire flash_mode_pkg::regwr_t  regWrite,
  input  wire logic                    rdEn,
  input  wire logic [7:0]              rdAddr,
  input  wire logic                    high_current_select,
  output logic [7:0]                   rdData,
  output logic                         rdAck,
  output flash_mode_pkg::opmode_t      operatingMode,
  output logic                         voltageSource,
  output logic                         shutdown,
  output flash_mode_pkg::drive_t       drive
);
  // ==========================================================
  // Register storage
  // ==========================================================
  logic [7:0]               centerReg_r;
  logic [7:0]               outerReg_r;
  logic                     refreshExpired;
  logic                     modeWrite;
  logic                     centerWrite;
  logic                     outerWrite;
  logic                     levelsZero;
  flash_mode_pkg::opstate_t state_r;

  // ==========================================================
  // Decode helpers
  // ==========================================================
  function automatic logic writeHits(input flash_mode_pkg::regwr_t wr,
                                     input logic [7:0]             addr);
    writeHits = wr.wrEn && (wr.addr == addr);
  endfunction : writeHits

  // Both levels at zero mean LEDs off and the converter regulating its output voltage.
  function automatic logic bothLevelsZero(input logic [7:0] center,
                                          input logic [7:0] outer);
    bothLevelsZero = (center[`CENTER_LEVEL_MSB:0] == 6'h00) &&
                     (outer[`OUTER_LEVEL_MSB:0] == 5'h00);
  endfunction : bothLevelsZero

  assign centerWrite = writeHits(regWrite, `CENTER_REG_ADDR);  // see [R14]
  assign outerWrite  = writeHits(regWrite, `OUTER_REG_ADDR);  // see [R14]
  // Both registers carry the mode select, so a write to either counts as a refresh.
  assign modeWrite   = centerWrite || outerWrite;
  assign levelsZero  = bothLevelsZero(centerReg_r, outerReg_r);

  // ==========================================================
  // Register updates
  // ==========================================================
  // A write beats a same-cycle expiry, so a refresh that arrives just in time is kept.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      centerReg_r <= `CENTER_REG_RESET;
    end
    else if (centerWrite)
    begin
      centerReg_r <= regWrite.data;  // see [R14]
    end
    else if (outerWrite)
    begin
      // Bits 6:5 are mirrored exactly as printed, so bit 5 lands in the centre level.
      centerReg_r[`MIRROR_MSB:`MIRROR_LSB] <=
        regWrite.data[`MIRROR_MSB:`MIRROR_LSB];  // see [R04]
    end
    else if (refreshExpired)
    begin
      centerReg_r[`MODE_MSB:`MODE_LSB] <= 2'h0;  // see [R15]
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      outerReg_r <= `OUTER_REG_RESET;
    end
    else if (outerWrite)
    begin
      outerReg_r <= regWrite.data;  // see [R14]
    end
    else if (centerWrite)
    begin
      outerReg_r[`MODE_MSB:`MODE_LSB] <= regWrite.data[`MODE_MSB:`MODE_LSB];  // see [R03]
    end
    else if (refreshExpired)
    begin
      outerReg_r[`MODE_MSB:`MODE_LSB] <= 2'h0;  // see [R02]
    end
  end

  // ==========================================================
  // Mode refresh timeout
  // ==========================================================
  refresh_timer #(
    .LIMIT (REFRESH_LIMIT)
  ) u_refresh (
    .clk     (clk),
    .reset_n (reset_n),
    .restart (modeWrite),  // see [R15]
    .expired (refreshExpired)
  );

  // ==========================================================
  // Read path
  // ==========================================================
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdData <= 8'h00;
      rdAck  <= 1'b0;
    end
    else
    begin
      rdAck <= rdEn;
      if (!rdEn)
        rdData <= rdData;
      else if (rdAddr == `CENTER_REG_ADDR)
        rdData <= centerReg_r;
      else if (rdAddr == `OUTER_REG_ADDR)
        rdData <= {outerReg_r[7:6], 1'b0, outerReg_r[4:0]};  // see [R06]
      else
        rdData <= 8'h00;
    end
  end

  // ==========================================================
  // Current scales
  // ==========================================================
  // Current figures are rounded to whole mA; the analog stage holds the exact steps.
  // Both scales are worked in quarter milliamps and rounded at the very end.
  function automatic logic [11:0] outerMa(input logic [4:0] code, input logic hc);
    logic [16:0] q;
    q = 17'h0;
    if (!hc)
    begin
      q = 17'(code) * 17'd111;  // see [R08]
    end
    else
    begin
      // The first high-current steps are irregular; from code 4 on the scale is linear.
      case (code)
        5'h00:   q = 17'h0;
        5'h01:   q = 17'd258;  // see [R09]
        5'h02:   q = 17'd508;  // see [R09]
        5'h03:   q = 17'd768;
        default: q = 17'(code) * 17'd257 - 17'd4;
      endcase
    end
    outerMa = 12'((q + 17'h2) >> 2);
  endfunction : outerMa

  function automatic logic [11:0] centerMa(input logic [5:0] code, input logic hc);
    logic [17:0] q;
    q = 18'h0;
    if (code == 6'h0)
      q = 18'h0;  // see [R10]
    else if (hc && code >= 6'h20)
      q = 18'd8208;  // see [R11]
    else if (hc)
      q = 18'(code) * 18'd256 + 18'd16;  // see [R11]
    else
      q = 18'(code) * 18'd111 + 18'h1;  // see [R10]
    centerMa = 12'((q + 18'h2) >> 2);
  endfunction : centerMa

  // ==========================================================
  // Operating state
  // ==========================================================
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= flash_mode_pkg::OP_OFF;
    else if (outerReg_r[`FORCE_BIT])
      state_r <= flash_mode_pkg::OP_VOLTAGE;  // see [R05]
    else
    begin
      case (flash_mode_pkg::opmode_t'(outerReg_r[7:6]))  // see [R01]
        flash_mode_pkg::MODE_SHUTDOWN: state_r <= flash_mode_pkg::OP_OFF;  // see [R12]
        flash_mode_pkg::MODE_DCLIGHT:  state_r <= flash_mode_pkg::OP_DCLIGHT;
        flash_mode_pkg::MODE_FLASH:    state_r <= flash_mode_pkg::OP_FLASH;
        flash_mode_pkg::MODE_VOLTAGE:  state_r <= flash_mode_pkg::OP_VOLTAGE;
        default:                       state_r <= flash_mode_pkg::OP_OFF;
      endcase
    end
  end

  // ==========================================================
  // Status outputs
  // ==========================================================
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      operatingMode <= flash_mode_pkg::MODE_SHUTDOWN;
      voltageSource <= 1'b0;
      shutdown      <= 1'b1;
    end
    else
    begin
      operatingMode <= flash_mode_pkg::opmode_t'(outerReg_r[`MODE_MSB:`MODE_LSB]);
      voltageSource <= (state_r == flash_mode_pkg::OP_VOLTAGE) || levelsZero;  // see [R07]
      shutdown      <= (state_r == flash_mode_pkg::OP_OFF);  // see [R12]
    end
  end

  // ==========================================================
  // Drive outputs
  // ==========================================================
  // The scale input is sampled with the levels, so a scale change shows after one edge.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drive <= '0;
    end
    else
    begin
      drive.ledsOn <= ((state_r == flash_mode_pkg::OP_DCLIGHT) ||
                       (state_r == flash_mode_pkg::OP_FLASH)) && !levelsZero;  // see [R07]
      drive.voltageReg     <= levelsZero;  // see [R07]
      drive.directDrive    <= !high_current_select;  // see [R13]
      drive.centerMilliAmp <= centerMa(centerReg_r[`CENTER_LEVEL_MSB:0], high_current_select);
      drive.outerMilliAmp  <= outerMa(outerReg_r[`OUTER_LEVEL_MSB:0], high_current_select);
    end
  end
endmodule : flash_mode_current_regs
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ====================
// Host side of the register port.
module host_model (
  input  wire logic                   clk,
  output var  flash_mode_pkg::regwr_t regWrite,
  output var  logic                   rdEn,
  output var  logic [7:0]             rdAddr
);
  initial
  begin
    regWrite = '0;
    rdEn     = 1'b0;
    rdAddr   = 8'h00;
  end
  // Released lines carry the inverse of the last value so stale data cannot pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= '{1'b1, a, d};
    @(posedge clk);
    regWrite <= '{1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rdEn   <= 1'b1;
    rdAddr <= a;
    @(posedge clk);
    rdEn   <= 1'b0;
    rdAddr <= ~a;
    #1;
  endtask : rd
endmodule : host_model
`default_nettype wire

/* File: tb/flash_regs_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// ====================
// Port checks.
module flash_regs_monitor #(
  parameter int unsigned REFRESH_LIMIT = 100
) (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire flash_mode_pkg::regwr_t  regWrite,
  input wire logic                    rdEn,
  input wire logic [7:0]              rdAddr,
  input wire logic                    high_current_select,
  input wire logic [7:0]              rdData,
  input wire logic                    rdAck,
  input wire flash_mode_pkg::opmode_t operatingMode,
  input wire logic                    voltageSource,
  input wire logic                    shutdown,
  input wire flash_mode_pkg::drive_t  drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  int unsigned idleCnt_r;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      idleCnt_r <= 0;
    else if (regWrite.wrEn && regWrite.addr inside {8'h01, 8'h02})
      idleCnt_r <= 0;
    else if (idleCnt_r < REFRESH_LIMIT + 8)
      idleCnt_r <= idleCnt_r + 1;
  a_ack_follows: assert property (rdEn |=> rdAck) else $error("no read ack");
  a_ack_single: assert property (!rdEn |=> !rdAck) else $error("stray read ack");
  a_unmapped_zero: assert property (rdEn && !(rdAddr inside {8'h01, 8'h02})
    |=> rdData == 8'h00) else $error("unmapped read not zero");
  a_force_hidden: assert property (rdEn && rdAddr == 8'h02 |=> !rdData[5])
    else $error("force bit visible");
  a_mirror_mode: assert property (regWrite.wrEn && regWrite.addr == 8'h01 ##1 !regWrite.wrEn
    ##1 rdEn && rdAddr == 8'h02 |=> rdData[7:6] == $past(regWrite.data[7:6], 3))
    else $error("mode not mirrored");
  a_leds_level: assert property (drive.ledsOn |-> drive.centerMilliAmp != 0
    || drive.outerMilliAmp != 0) else $error("leds on at zero level");
  a_direct_drive: assert property ($stable(high_current_select)[*3]
    |-> drive.directDrive == !high_current_select) else $error("drive source wrong");
  a_mode_awake: assert property ((operatingMode != flash_mode_pkg::MODE_SHUTDOWN)[*4]
    |-> !shutdown) else $error("shutdown in active mode");
  a_voltage_mode: assert property ((operatingMode == flash_mode_pkg::MODE_VOLTAGE)[*4]
    |-> voltageSource) else $error("voltage mode missing");
  a_mode_timeout: assert property (idleCnt_r == REFRESH_LIMIT + 4
    |-> operatingMode == flash_mode_pkg::MODE_SHUTDOWN) else $error("no refresh timeout");
  c_read: cover property (rdEn && rdAddr == 8'h02);
  c_high: cover property (drive.ledsOn && !drive.directDrive);
  c_expire: cover property (idleCnt_r == REFRESH_LIMIT + 4);
endmodule : flash_regs_monitor
bind flash_mode_current_regs flash_regs_monitor #(.REFRESH_LIMIT(REFRESH_LIMIT)) i_mon (
  .clk, .reset_n, .regWrite, .rdEn, .rdAddr, .high_current_select, .rdData, .rdAck,
  .operatingMode, .voltageSource, .shutdown, .drive);
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
// ====================
// Scenarios.
module testbench;
  localparam int unsigned LIM = 100;
  logic                    clk = 1'b0;
  logic                    reset_n = 1'b0;
  logic                    hiCur = 1'b0;
  flash_mode_pkg::regwr_t  regWrite;
  logic                    rdEn;
  logic [7:0]              rdAddr;
  logic [7:0]              rdData;
  logic                    rdAck;
  flash_mode_pkg::opmode_t opMode;
  logic                    voltSrc;
  logic                    down;
  flash_mode_pkg::drive_t  drv;
  int                      badCount = 0;
  int                      checksDone = 0;
  always #4 clk = ~clk;
  host_model i_host (.clk(clk), .regWrite(regWrite), .rdEn(rdEn), .rdAddr(rdAddr));
  flash_mode_current_regs #(.REFRESH_LIMIT(LIM)) i_dut (.clk(clk), .reset_n(reset_n),
    .regWrite(regWrite), .rdEn(rdEn), .rdAddr(rdAddr), .high_current_select(hiCur),
    .rdData(rdData), .rdAck(rdAck), .operatingMode(opMode), .voltageSource(voltSrc),
    .shutdown(down), .drive(drv));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      badCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a);
    check({rdAck, rdData}, {3'h1, e});
  endtask : rdChk
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task automatic resetAndMirror;
    rdChk(8'h01, 8'h10);
    rdChk(8'h02, 8'h08);
    i_host.wr(8'h03, 8'hff);
    rdChk(8'h07, 8'h00);
    rdChk(8'h01, 8'h10);
    i_host.wr(8'h01, 8'hc5);
    rdChk(8'h02, 8'hc8);
    i_host.wr(8'h02, 8'h7f);
    rdChk(8'h02, 8'h5f);
    rdChk(8'h01, 8'he5);
  endtask : resetAndMirror
  task automatic modesAndForce;
    i_host.wr(8'h02, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      i_host.wr(8'h01, {m[1:0], 6'h01});
      settle();
      check(opMode, 12'(m));
      check(down, 12'(m == 0));
      check(voltSrc, 12'(m == 3));
    end
    i_host.wr(8'h02, 8'h21);
    settle();
    check(down, 12'h000);
    check(voltSrc, 12'h001);
    rdChk(8'h02, 8'h01);
  endtask : modesAndForce
  task automatic levels;
    i_host.wr(8'h02, 8'h82);
    i_host.wr(8'h01, 8'h81);
    settle();
    check(drv.centerMilliAmp, 12'd28);
    check(drv.outerMilliAmp inside {12'd55, 12'd56}, 12'h001);
    check(drv.directDrive, 12'h001);
    @(posedge clk);
    hiCur <= 1'b1;
    i_host.wr(8'h01, 8'ha0);
    settle();
    check(drv.centerMilliAmp, 12'd2052);
    check(drv.outerMilliAmp, 12'd127);
    check(drv.directDrive, 12'h000);
    i_host.wr(8'h01, 8'h9f);
    settle();
    check(drv.centerMilliAmp, 12'd1988);
    i_host.wr(8'h01, 8'h80);
    i_host.wr(8'h02, 8'h80);
    settle();
    check({drv.ledsOn, drv.voltageReg, voltSrc}, 12'h003);
  endtask : levels
  task automatic refresh;
    i_host.wr(8'h01, 8'h40);
    repeat (3)
    begin
      repeat (LIM - 40) @(posedge clk);
      i_host.wr(8'h01, 8'h40);
    end
    settle();
    check(opMode, 12'h001);
    repeat (LIM + 8) @(posedge clk);
    #1;
    check({opMode, down}, 12'h001);
    rdChk(8'h01, 8'h00);
  endtask : refresh
  task automatic wrapUp;
    $display("checks=%0d bad=%0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrapUp
  // The run needs about 400 cycles; the watchdog allows many times that.
  initial
  begin
    #200000;
    badCount++;
    wrapUp();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    resetAndMirror();
    modesAndForce();
    levels();
    refresh();
    wrapUp();
  end
endmodule : testbench
`default_nettype wire
